// [rtl/lever_fault_regs.vh]
// Purpose: Shared constants for the lever and sensor fault monitor
// Assumes: 125 MHz system clock, times kept in milliseconds
// Notes:   Definitions only
`ifndef LEVER_FAULT_REGS_VH
`define LEVER_FAULT_REGS_VH

`define CLK_PERIOD_PS    8000
`define MS_PS            1000000000
`define SHIFT_NONE_MS    11'h708
`define SPEED_HOLD_MS    11'h190
`define SUPPLY_LOW_MS    11'h014
`define LIFT_OFF_MS      11'h190
`define LEVER_OPEN_PCT   8'h14
`define SPEED_LIMIT_KMH  8'h1e

`define CODE_NONE        8'h00
`define CODE_ATT3_NEUT   8'h0e
`define CODE_SHIFT       8'h10
`define CODE_SPEED       8'h11
`define CODE_SHIFT_CAN   8'h14
`define CODE_TILT_CAN    8'h16
`define CODE_ATT1_CAN    8'h18
`define CODE_ATT2_CAN    8'h1a
`define CODE_ATT3_CAN    8'h1c
`define CODE_JOYSTICK    8'h1d
`define CODE_SUPPLY      8'h1f

`define WB_ATT3_NEUT     0
`define WB_SHIFT         1
`define WB_SPEED         2
`define WB_CAN_LO        3
`define WB_CAN_HI        7
`define WB_JOYSTICK      8
`define WB_SUPPLY        9
`define WARN_N           10

`endif

// [rtl/pin_sync.v]
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   Output changes only when stages two and three agree
`default_nettype none
`timescale 1ns/1ps
module pin_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_b,
    input  wire [W-1:0] pin_in,
    output reg  [W-1:0] stable_q
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    integer i;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q     <= {W{1'b0}};
            s2_q     <= {W{1'b0}};
            s3_q     <= {W{1'b0}};
            stable_q <= {W{1'b0}};
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    stable_q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // pin_sync
`default_nettype wire

// [rtl/persist_timer.v]
// Purpose: Qualifies a condition that must hold for COUNT+1 millisecond ticks
// Assumes: tick is a one-cycle pulse once per millisecond
// Notes:   Any drop of cond restarts from zero
`default_nettype none
`timescale 1ns/1ps
module persist_timer #(
    parameter CNT_W = 11,
    parameter [CNT_W-1:0] COUNT = 11'h001
) (
    input  wire clk,
    input  wire rst_b,
    input  wire tick,
    input  wire cond,
    output reg  done_q
);
    reg [CNT_W-1:0] cnt_q;

    // COUNT+1 ticks are needed, since the first tick may land right after cond rises
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q  <= {CNT_W{1'b0}};
            done_q <= 1'b0;
        end else if (!cond) begin
            cnt_q  <= {CNT_W{1'b0}};
            done_q <= 1'b0;
        end else if (tick) begin
            if (cnt_q == COUNT) begin
                done_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule // persist_timer
`default_nettype wire

// [rtl/lever_sensor_fault_monitor.v]
// Purpose: Lever, shift, speed and sensor supply fault supervision
// Assumes: Single 125 MHz clock, async active-low power-on reset
// Notes:   Latched warnings clear only through rst_b (power cycle)
`include "lever_fault_regs.vh"
`default_nettype none
`timescale 1ns/1ps
module lever_sensor_fault_monitor #(
    parameter MS_TICK_CYCLES = `MS_PS / `CLK_PERIOD_PS,
    parameter TICK_W         = 17,
    parameter LEVER_W        = 8,
    parameter SPEED_W        = 8,
    parameter CUR_W          = 12,
    parameter FUNC_N         = 4
) (
    input  wire               clk,
    input  wire               rst_b,
    input  wire               key_on,
    input  wire               shift_fwd,
    input  wire               shift_rev,
    input  wire               shift_neutral,
    input  wire               supply_low,
    input  wire               photo_in,
    input  wire [LEVER_W-1:0] att3_open_pct,
    input  wire [SPEED_W-1:0] speed_kmh,
    input  wire [4:0]         can_lever_abn,
    input  wire               joy_pri_abn,
    input  wire               joy_sec_abn,
    input  wire [FUNC_N-1:0]  func_sol_req,
    input  wire               unload_req,
    input  wire               tm_fwd_req,
    input  wire               tm_rev_req,
    input  wire               lift_req,
    input  wire [CUR_W-1:0]   lift_cur_req,
    input  wire               lift_lock_req,
    input  wire               steer_req,
    input  wire               tilt_lock_req,
    output reg  [FUNC_N-1:0]  func_sol_q,
    output reg                unload_sol_q,
    output reg                tm_fwd_q,
    output reg                tm_rev_q,
    output reg                lift_sol_q,
    output reg  [CUR_W-1:0]   lift_cur_q,
    output reg                lift_lock_q,
    output reg                steer_q,
    output reg                tilt_lock_q,
    output reg  [SPEED_W-1:0] speed_tx_q,
    output reg                shift_lock_speed_valid_q,
    output reg                speed_valid_q,
    output reg                photo_q,
    output reg                tilt_autostop_en_q,
    output reg                sensor_diag_en_q,
    output reg                aux_diag_en_q,
    output reg                sol_diag_en_q,
    output reg  [`WARN_N-1:0] warn_flags_q,
    output reg  [7:0]         warn_code_q
);
    localparam [31:0]       MS_LAST_W = MS_TICK_CYCLES - 1;
    // Cut to the counter width on purpose; TICK_W must cover MS_TICK_CYCLES
    localparam [TICK_W-1:0] MS_LAST   = MS_LAST_W[TICK_W-1:0];

    wire [5:0]   pins_s;
    wire         key_s;
    wire         fwd_s;
    wire         rev_s;
    wire         neut_s;
    wire         low_s;
    wire         photo_s;
    wire         none_done;
    wire         speed_done;
    wire         supply_done;
    wire         lift_off_done;
    wire         lift_fault;
    reg  [TICK_W-1:0] ms_cnt_q;
    reg          ms_tick_q;
    reg          f14_q;
    reg          f16_q;
    reg  [4:0]   can_abn_q;
    reg          f29_q;
    reg          f31_q;
    reg  [7:0]   code_d;
    wire [`WARN_N-1:0] flags_d;

    pin_sync #(
        .W(6)
    ) u_pin_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .pin_in   ({key_on, shift_fwd, shift_rev, shift_neutral, supply_low, photo_in}),
        .stable_q (pins_s)
    );

    assign key_s   = pins_s[5];
    assign fwd_s   = pins_s[4];
    assign rev_s   = pins_s[3];
    assign neut_s  = pins_s[2];
    assign low_s   = pins_s[1];
    assign photo_s = pins_s[0];

    // Millisecond time base keeps the qualification counters narrow
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ms_cnt_q  <= {TICK_W{1'b0}};
            ms_tick_q <= 1'b0;
        end else if (ms_cnt_q == MS_LAST) begin
            ms_cnt_q  <= {TICK_W{1'b0}};
            ms_tick_q <= 1'b1;
        end else begin
            ms_cnt_q  <= ms_cnt_q + 1'b1;
            ms_tick_q <= 1'b0;
        end
    end

    persist_timer #(
        .CNT_W (11),
        .COUNT (`SHIFT_NONE_MS)
    ) u_shift_none (
        .clk    (clk),
        .rst_b  (rst_b),
        .tick   (ms_tick_q),
        .cond   (!fwd_s && !rev_s && !neut_s),
        .done_q (none_done)
    );

    persist_timer #(
        .CNT_W (11),
        .COUNT (`SPEED_HOLD_MS)
    ) u_speed (
        .clk    (clk),
        .rst_b  (rst_b),
        .tick   (ms_tick_q),
        .cond   (speed_kmh > `SPEED_LIMIT_KMH),
        .done_q (speed_done)
    );

    persist_timer #(
        .CNT_W (11),
        .COUNT (`SUPPLY_LOW_MS)
    ) u_supply (
        .clk    (clk),
        .rst_b  (rst_b),
        .tick   (ms_tick_q),
        .cond   (low_s),
        .done_q (supply_done)
    );

    assign lift_fault = |can_abn_q;

    persist_timer #(
        .CNT_W (11),
        .COUNT (`LIFT_OFF_MS)
    ) u_lift_off (
        .clk    (clk),
        .rst_b  (rst_b),
        .tick   (ms_tick_q),
        .cond   (lift_fault),
        .done_q (lift_off_done)
    );

    // Warning state; set terms win over clear terms
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            f14_q     <= 1'b0;
            f16_q     <= 1'b0;
            can_abn_q <= 5'h00;
            f29_q     <= 1'b0;
            f31_q     <= 1'b0;
        end else begin
            f14_q <= key_s && (att3_open_pct >= `LEVER_OPEN_PCT);
            if ((fwd_s && rev_s) || none_done) begin
                f16_q <= 1'b1;
            end else if (neut_s) begin
                f16_q <= 1'b0;
            end
            can_abn_q <= can_abn_q | can_lever_abn;
            if (joy_pri_abn && joy_sec_abn) begin
                f29_q <= 1'b1;
            end
            if (supply_done) begin
                f31_q <= 1'b1;
            end
        end
    end

    assign flags_d = {f31_q, f29_q, can_abn_q, speed_done, f16_q, f14_q};

    // Lowest code wins on the indication output
    always @* begin
        code_d = `CODE_NONE;
        if (f31_q)        code_d = `CODE_SUPPLY;
        if (f29_q)        code_d = `CODE_JOYSTICK;
        if (can_abn_q[4]) code_d = `CODE_ATT3_CAN;
        if (can_abn_q[3]) code_d = `CODE_ATT2_CAN;
        if (can_abn_q[2]) code_d = `CODE_ATT1_CAN;
        if (can_abn_q[1]) code_d = `CODE_TILT_CAN;
        if (can_abn_q[0]) code_d = `CODE_SHIFT_CAN;
        if (speed_done)   code_d = `CODE_SPEED;
        if (f16_q)        code_d = `CODE_SHIFT;
        if (f14_q)        code_d = `CODE_ATT3_NEUT;
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            func_sol_q               <= {FUNC_N{1'b0}};
            unload_sol_q             <= 1'b0;
            tm_fwd_q                 <= 1'b0;
            tm_rev_q                 <= 1'b0;
            lift_sol_q               <= 1'b0;
            lift_cur_q               <= {CUR_W{1'b0}};
            lift_lock_q              <= 1'b0;
            steer_q                  <= 1'b0;
            tilt_lock_q              <= 1'b0;
            speed_tx_q               <= {SPEED_W{1'b0}};
            shift_lock_speed_valid_q <= 1'b0;
            speed_valid_q            <= 1'b0;
            photo_q                  <= 1'b0;
            tilt_autostop_en_q       <= 1'b0;
            sensor_diag_en_q         <= 1'b0;
            aux_diag_en_q            <= 1'b0;
            sol_diag_en_q            <= 1'b0;
            warn_flags_q             <= {`WARN_N{1'b0}};
            warn_code_q              <= `CODE_NONE;
        end else begin
            func_sol_q <= f14_q ? {FUNC_N{1'b0}} : func_sol_req;
            // Supply hold outranks the forced-off terms: outputs keep their state
            if (!f31_q) begin
                unload_sol_q <= unload_req && !f14_q;
                tm_fwd_q     <= tm_fwd_req && !f16_q;
                tm_rev_q     <= tm_rev_req && !f16_q;
                lift_lock_q  <= lift_lock_req;
                steer_q      <= steer_req;
                tilt_lock_q  <= tilt_lock_req;
                photo_q      <= photo_s;
            end
            sol_diag_en_q      <= !f31_q;
            lift_cur_q         <= lift_fault ? {CUR_W{1'b0}} : lift_cur_req;
            lift_sol_q         <= lift_req && !lift_off_done;
            speed_tx_q         <= speed_done ? {SPEED_W{1'b0}} : speed_kmh;
            shift_lock_speed_valid_q <= !speed_done;
            speed_valid_q      <= 1'b1;
            aux_diag_en_q      <= !f31_q;
            tilt_autostop_en_q <= !f31_q;
            sensor_diag_en_q   <= !f31_q;
            warn_flags_q       <= flags_d;
            warn_code_q        <= code_d;
        end
    end
endmodule // lever_sensor_fault_monitor
`default_nettype wire

// [testbench/unit_can_model.sv]
// Purpose: Input unit seen over CAN: lever and joystick abnormal flags
// Assumes: Shares clk with the monitor
// Notes:   slow adds four cycles of lag, as a busy bus would
`timescale 1ns/1ps
`default_nettype none
module unit_can_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       slow,
    input  wire logic [6:0] req,
    output wire logic [4:0] can_lever_abn,
    output wire logic       joy_pri_abn,
    output wire logic       joy_sec_abn
);
    logic [34:0] pipe_q;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            pipe_q <= '0;
        else
            pipe_q <= {pipe_q[27:0], req};
    end
    assign {joy_sec_abn, joy_pri_abn, can_lever_abn} = slow ? pipe_q[34:28] : pipe_q[6:0];
endmodule // unit_can_model
`default_nettype wire

// [testbench/fault_monitor_checker.sv]
// Purpose: Port-level assertions for the fault monitor
// Assumes: Bound into lever_sensor_fault_monitor
// Notes:   Flags and gated outputs register on the same edge; inputs reach flags two edges on
`timescale 1ns/1ps
`default_nettype none
module fault_monitor_checker (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [7:0]  att3_open_pct,
    input wire logic [7:0]  speed_kmh,
    input wire logic [4:0]  can_lever_abn,
    input wire logic        joy_pri_abn,
    input wire logic        joy_sec_abn,
    input wire logic [3:0]  func_sol_q,
    input wire logic        tm_fwd_q,
    input wire logic        tm_rev_q,
    input wire logic [11:0] lift_cur_q,
    input wire logic [7:0]  speed_tx_q,
    input wire logic        shift_lock_speed_valid_q,
    input wire logic        speed_valid_q,
    input wire logic        photo_q,
    input wire logic        steer_q,
    input wire logic        sol_diag_en_q,
    input wire logic [9:0]  warn_flags_q,
    input wire logic [7:0]  warn_code_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_F14_CODE: assert property (warn_flags_q[0] |-> warn_code_q == 8'h0e) else $error("bad code");
    AST_F14_GATE: assert property (warn_flags_q[0] |-> func_sol_q == 4'h0) else $error("func on");
    AST_F14_CLR: assert property (att3_open_pct < 8'h14 |=> ##1 !warn_flags_q[0]) else $error("F14 held");
    AST_F16_TM: assert property (warn_flags_q[1] && !warn_flags_q[9] |-> !tm_fwd_q && !tm_rev_q) else $error("tm on");
    AST_F17_CLR: assert property (speed_kmh <= 8'h1e |=> ##1 !warn_flags_q[2]) else $error("F17 held");
    AST_F17_TX: assert property (warn_flags_q[2] |-> speed_tx_q == 8'h00 && !shift_lock_speed_valid_q)
        else $error("speed sent");
    AST_LIFT_CUR: assert property ($rose(|can_lever_abn) |-> ##[1:2] lift_cur_q == 12'h000) else $error("cur");
    // Latched bits may only rise; only reset clears them
    AST_LATCH: assert property ((warn_flags_q[9:3] & $past(warn_flags_q[9:3])) == $past(warn_flags_q[9:3]))
        else $error("latch lost");
    AST_JOY: assert property (joy_pri_abn && joy_sec_abn |=> ##1 warn_flags_q[8]) else $error("F29 missing");
    AST_F31_HOLD: assert property (warn_flags_q[9] |=> $stable(photo_q) && $stable(steer_q) && !sol_diag_en_q
        && speed_valid_q) else $error("F31 hold");
    cover property (warn_flags_q[1]);
    cover property (warn_flags_q[2]);
    cover property (warn_flags_q[9]);
endmodule // fault_monitor_checker
`default_nettype wire

// [testbench/tb_lever_sensor_fault_monitor.sv]
// Purpose: Self-checking bench for the fault monitor
// Assumes: 4-cycle millisecond tick shortens every timer
// Notes:   Flag changes are matched against a queue of notes
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, a, e); end end
module tb_lever_sensor_fault_monitor;
    logic        clk, rst_b, key_on, shift_fwd, shift_rev, shift_neutral, supply_low, photo_in;
    logic        lift_req, steer_req, slow, unload_req, tm_fwd_req, tm_rev_req, lift_lock_req, tilt_lock_req;
    logic [7:0]  att3_open_pct, speed_kmh;
    logic [3:0]  func_sol_req;
    logic [11:0] lift_cur_req;
    logic [6:0]  req;
    wire  [4:0]  can_lever_abn;
    wire         joy_pri_abn, joy_sec_abn, unload_sol_q, tm_fwd_q, tm_rev_q, lift_sol_q, steer_q, photo_q;
    wire         shift_lock_speed_valid_q, speed_valid_q, sol_diag_en_q;
    wire         lift_lock_q, tilt_lock_q, tilt_autostop_en_q, sensor_diag_en_q, aux_diag_en_q;
    wire  [3:0]  func_sol_q;
    wire  [11:0] lift_cur_q;
    wire  [7:0]  speed_tx_q, warn_code_q;
    wire  [9:0]  warn_flags_q;
    logic [17:0] notes [$];
    logic [17:0] exp_n;
    logic [9:0]  seen = 10'h000;
    logic [31:0] seed = 32'h37;
    logic [7:0]  codes [5] = '{8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c};
    int          fail_count, n_tests;
    lever_sensor_fault_monitor #(.MS_TICK_CYCLES(4)) DUT (.*);
    unit_can_model PART (.*);
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic note(input logic [9:0] f, input logic [7:0] c);
        notes.push_back({f, c});
    endtask
    // Bounded so a missing flag cannot hang the run
    task automatic await(input int b, input logic v);
        for (int k = 0; k < 300 && warn_flags_q[b] !== v; k++) cyc(1);
        `CHK(warn_flags_q[b], v)
    endtask
    task automatic reset_dut();
        rst_b = 0;
        cyc(3);
        rst_b = 1;
    endtask
    task automatic summarize();
        `CHK(notes.size(), 0)
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        #2;
        if (warn_flags_q !== seen) begin
            seen = warn_flags_q;
            exp_n = notes.size() ? notes.pop_front() : 18'h3ffff;
            `CHK({warn_flags_q, warn_code_q}, exp_n)
        end
    end
    initial begin
        #400000;
        fail_count++;
        summarize();
    end
    initial begin
        {key_on, shift_fwd, shift_rev, supply_low, photo_in, lift_req, steer_req, slow} = '0;
        {att3_open_pct, speed_kmh, lift_cur_req, req} = '0;
        shift_neutral = 1;
        {unload_req, tm_fwd_req, tm_rev_req, lift_lock_req, tilt_lock_req} = 5'h1f;
        func_sol_req = 4'(rnd()) | 4'h1;
        reset_dut();
        key_on = 1;
        cyc(6);
        `CHK(func_sol_q, func_sol_req)
        att3_open_pct = 8'h14;
        note(10'h001, 8'h0e);
        await(0, 1);
        cyc(1);
        `CHK({func_sol_q, unload_sol_q}, 5'h00)
        att3_open_pct = 8'h13;
        note(10'h000, 8'h00);
        await(0, 0);
        cyc(1);
        `CHK(unload_sol_q, 1'b1)
        $display("test neutral done");
        {shift_fwd, shift_rev, shift_neutral} = 3'b110;
        note(10'h002, 8'h10);
        await(1, 1);
        cyc(1);
        `CHK({tm_fwd_q, tm_rev_q}, 2'b00)
        {shift_fwd, shift_rev, shift_neutral} = 3'b001;
        note(10'h000, 8'h00);
        await(1, 0);
        cyc(1);
        `CHK({tm_fwd_q, tm_rev_q}, 2'b11)
        shift_neutral = 0;
        cyc(7000);
        `CHK(warn_flags_q[1], 1'b0)
        note(10'h002, 8'h10);
        await(1, 1);
        shift_neutral = 1;
        note(10'h000, 8'h00);
        await(1, 0);
        $display("test shift done");
        speed_kmh = 8'h1f;
        cyc(1500);
        speed_kmh = 8'h1e;
        cyc(1);
        speed_kmh = 8'h1f;
        cyc(1500);
        `CHK(warn_flags_q[2], 1'b0)
        note(10'h004, 8'h11);
        await(2, 1);
        cyc(1);
        `CHK({speed_tx_q, shift_lock_speed_valid_q}, 9'h000)
        speed_kmh = 8'h1e;
        note(10'h000, 8'h00);
        await(2, 0);
        cyc(1);
        `CHK({speed_tx_q, shift_lock_speed_valid_q}, 9'h03d)
        $display("test speed done");
        lift_req = 1;
        for (int i = 0; i < 5; i++) begin
            lift_cur_req = 12'(rnd()) | 12'h001;
            slow = i[0];
            cyc(2);
            `CHK(lift_cur_q, lift_cur_req)
            req = 7'(1 << i);
            note(10'(8 << i), codes[i]);
            await(3 + i, 1);
            `CHK(lift_cur_q, 12'h000)
            cyc(1400);
            `CHK(lift_sol_q, 1'b1)
            req = '0;
            cyc(300);
            `CHK({lift_sol_q, warn_flags_q[3 + i]}, 2'b01)
            note(10'h000, 8'h00);
            reset_dut();
        end
        $display("test lever done");
        cyc(6);
        photo_in = 1;
        steer_req = 1;
        req = 7'h60;
        note(10'h100, 8'h1d);
        await(8, 1);
        `CHK(func_sol_q, func_sol_req)
        `CHK({tilt_autostop_en_q, sensor_diag_en_q, aux_diag_en_q}, 3'b111)
        supply_low = 1;
        note(10'h300, 8'h1d);
        await(9, 1);
        {photo_in, steer_req, supply_low, lift_lock_req, tilt_lock_req} = 5'h00;
        cyc(8);
        `CHK({photo_q, steer_q, sol_diag_en_q, speed_valid_q}, 4'b1101)
        `CHK({lift_lock_q, tilt_lock_q, tilt_autostop_en_q, sensor_diag_en_q, aux_diag_en_q}, 5'h18)
        $display("test supply done");
        summarize();
    end
endmodule // tb_lever_sensor_fault_monitor
bind lever_sensor_fault_monitor fault_monitor_checker CHECK_I (.*);
`default_nettype wire
